/* File: tsc_defines.svh */
// offsets, field positions, reset values for the supply charge control block
`ifndef TSC_DEFINES_SVH
`define TSC_DEFINES_SVH

// register word offsets on the plain register port
`define TSC_ADDR_W           4
`define TSC_DATA_W           8
`define TSC_ADDR_CTRL        4'h0
`define TSC_ADDR_LEVEL       4'h1
`define TSC_ADDR_STATUS      4'h2

// control register fields
`define TSC_CTRL_REG_OFF_BIT     0
`define TSC_CTRL_NO_LISTEN_BIT   1
`define TSC_CTRL_REQUEST_BIT     2

// level register fields
`define TSC_LEVEL_TARGET_LSB     0
`define TSC_LEVEL_TARGET_MSB     3
`define TSC_LEVEL_CURRENT_LSB    4
`define TSC_LEVEL_CURRENT_MSB    7

// status word fields
`define TSC_STAT_REACHED_BIT     0
`define TSC_STAT_CHARGING_BIT    1
`define TSC_STAT_SUSPENDED_BIT   2
`define TSC_STAT_OFF_BIT         3

// reset values: regulation off after power-up
`define TSC_CTRL_RESET       8'h01
`define TSC_LEVEL_RESET      8'h00

`endif

/* File: tsc_pkg.sv */
// types shared by the supply charge control block
package tsc_pkg;

	// charger control states
	typedef enum logic [1:0] {
		TSC_ST_OFF,
		TSC_ST_CHARGE,
		TSC_ST_HOLD,
		TSC_ST_SUSPEND
	} tsc_state_t;

	// complete state of the block, registered as one word
	typedef struct packed {
		tsc_state_t  state;
		logic        reg_off;
		logic        no_listen;
		logic        request;
		logic [3:0]  target;
		logic [3:0]  current;
		logic [2:0]  above_sync;
		logic        above;
		logic        burst_d;
		logic        req_at_burst;
		logic        charge_on;
		logic        reached;
		logic [7:0]  rdata;
	} tsc_regs_t;

endpackage

/* File: tsc_charge_ctrl.sv */
// charge regulator control for the transformer centre-tap supply
//
// Functional notes
// - supply regulated by a voltage monitor; target from supply_target_level field
// - charging current source switches off once supply crosses the target
// - charge current magnitude follows the charge_current_level field
// - regulation-off bit set after power-up; software clears it to enable
// - with regulation on, charger re-enables intermittently as capacitor discharges
// - no_recharge_while_listening stops charging automatically when a burst ends
// - setting recharge_request turns supply charging back on
// - status word reports supply_level_reached when target voltage attained
// - request still set at the burst prevents the automatic stop
// - suppression and request behaviour ignored while regulation is off
//
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/1ns
`include "tsc_defines.svh"

module tsc_charge_ctrl (
	input  wire logic                     clk_sys_in,
	input  wire logic                     rst_n_in,
	input  wire logic [`TSC_ADDR_W-1:0]   addr_in,
	input  wire logic [`TSC_DATA_W-1:0]   wdata_in,
	input  wire logic                     wr_in,
	input  wire logic                     rd_in,
	input  wire logic                     supply_above_target_in,
	input  wire logic                     burst_active_in,
	output logic      [`TSC_DATA_W-1:0]   rdata_out,
	output logic                          charge_enable_out,
	output logic      [3:0]               supply_target_level_out,
	output logic      [3:0]               charge_current_level_out,
	output logic                          supply_regulation_off_out,
	output logic                          supply_level_reached_out
);

	// register map, one byte per word:
	//   control  bit 0 regulation off, bit 1 no recharge while listening,
	//            bit 2 recharge request
	//   level    low nibble supply target level, high nibble charge current level
	//   status   bit 0 level reached, bit 1 charging, bit 2 suspended,
	//            bit 3 regulation off; read only
	// charger states:
	//   off      regulation disabled; current source off, supply pin left floating
	//   charge   current source on until the monitor reports the target
	//   hold     target reached; waits for the supply capacitor to sag
	//   suspend  listen phase; no recharge until software asks for one
	// the monitor comparator is analog and free running, so it is filtered before
	// it steers anything; a one-cycle glitch never moves the charger
	// the burst flag comes from logic on this clock and is used unfiltered
	// limitation: the filter adds about four cycles between crossing and switch-off

	tsc_pkg::tsc_regs_t r_reg;
	tsc_pkg::tsc_regs_t r_next;

	// decoded strobes and events
	logic wr_ctrl;
	logic wr_level;
	logic rd_status;
	logic req_set_evt;
	logic burst_start;
	logic burst_end;
	logic suppress_hit;
	logic [3:0] wdata_target;
	logic [3:0] wdata_current;

	assign wr_ctrl       = wr_in && (addr_in == `TSC_ADDR_CTRL);
	assign wr_level      = wr_in && (addr_in == `TSC_ADDR_LEVEL);
	assign rd_status     = rd_in && (addr_in == `TSC_ADDR_STATUS);
	assign req_set_evt   = wr_ctrl && wdata_in[`TSC_CTRL_REQUEST_BIT];
	assign burst_start   = burst_active_in && !r_reg.burst_d;
	assign burst_end     = !burst_active_in && r_reg.burst_d;
	assign wdata_target  = wdata_in[`TSC_LEVEL_TARGET_MSB:`TSC_LEVEL_TARGET_LSB];
	assign wdata_current = wdata_in[`TSC_LEVEL_CURRENT_MSB:`TSC_LEVEL_CURRENT_LSB];
	// automatic stop only when the request was clear at burst start
	assign suppress_hit  = burst_end && r_reg.no_listen && !r_reg.req_at_burst;

	// next-state logic for the whole block
	always_comb
	begin
		r_next = r_reg;

		// monitor comparator is asynchronous: three stages, act once 2nd and 3rd agree
		r_next.above_sync = {r_reg.above_sync[1:0], supply_above_target_in};
		if (r_reg.above_sync[1] == r_reg.above_sync[2])
		begin
			r_next.above = r_reg.above_sync[2];
		end
		r_next.burst_d = burst_active_in;

		// writes land one edge later; this port never inserts wait states
		// register writes
		if (wr_ctrl)
		begin
			r_next.reg_off   = wdata_in[`TSC_CTRL_REG_OFF_BIT];
			r_next.no_listen = wdata_in[`TSC_CTRL_NO_LISTEN_BIT];
			r_next.request   = wdata_in[`TSC_CTRL_REQUEST_BIT];
		end
		if (wr_level)
		begin
			r_next.target  = wdata_target;
			r_next.current = wdata_current;
		end

		// request is judged by its value when the burst starts
		// a request written during the burst itself does not count for that burst
		if (burst_start)
		begin
			r_next.req_at_burst = r_reg.request;
		end

		// charger state machine
		// off always steps to charge; the off-bit override below pulls it back
		case (r_reg.state)
			tsc_pkg::TSC_ST_OFF:
			begin
				r_next.state = tsc_pkg::TSC_ST_CHARGE;
			end
			tsc_pkg::TSC_ST_CHARGE:
			begin
				if (r_reg.above)
				begin
					r_next.state = tsc_pkg::TSC_ST_HOLD;
				end
			end
			tsc_pkg::TSC_ST_HOLD:
			begin
				if (!r_reg.above)
				begin
					r_next.state = tsc_pkg::TSC_ST_CHARGE;
				end
			end
			tsc_pkg::TSC_ST_SUSPEND:
			begin
				r_next.state = tsc_pkg::TSC_ST_SUSPEND;
			end
			default:
			begin
				r_next.state = tsc_pkg::TSC_ST_OFF;
			end
		endcase

		// listen-phase suppression after a burst
		if (suppress_hit && (r_reg.state != tsc_pkg::TSC_ST_OFF))
		begin
			r_next.state = tsc_pkg::TSC_ST_SUSPEND;
		end
		// a request set by software wins over a stop in the same cycle
		if (req_set_evt && (r_next.state == tsc_pkg::TSC_ST_SUSPEND))
		begin
			r_next.state = tsc_pkg::TSC_ST_CHARGE;
		end
		// regulation off overrides everything, suppression included
		if (r_reg.reg_off)
		begin
			r_next.state = tsc_pkg::TSC_ST_OFF;
		end

		// registered outputs derived from the new state
		// taken from the next state so the outputs move in step with it
		r_next.charge_on = (r_next.state == tsc_pkg::TSC_ST_CHARGE);
		r_next.reached   = r_next.above && (r_next.state != tsc_pkg::TSC_ST_OFF);

		// read data stands one cycle after the read strobe only
		// zero between reads so a stray sample never sees stale data
		r_next.rdata = 8'h00;
		if (rd_in)
		begin
			case (addr_in)
				`TSC_ADDR_CTRL:
				begin
					r_next.rdata[`TSC_CTRL_REG_OFF_BIT]   = r_reg.reg_off;
					r_next.rdata[`TSC_CTRL_NO_LISTEN_BIT] = r_reg.no_listen;
					r_next.rdata[`TSC_CTRL_REQUEST_BIT]   = r_reg.request;
				end
				`TSC_ADDR_LEVEL:
				begin
					r_next.rdata = {r_reg.current, r_reg.target};
				end
				`TSC_ADDR_STATUS:
				begin
					r_next.rdata[`TSC_STAT_REACHED_BIT]   = r_reg.reached;
					r_next.rdata[`TSC_STAT_CHARGING_BIT]  = r_reg.charge_on;
					r_next.rdata[`TSC_STAT_SUSPENDED_BIT] =
						(r_reg.state == tsc_pkg::TSC_ST_SUSPEND);
					r_next.rdata[`TSC_STAT_OFF_BIT]       = r_reg.reg_off;
				end
				default:
				begin
					r_next.rdata = 8'h00;
				end
			endcase
		end
	end

	// state register; regulation starts switched off
	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			r_reg         <= '0;
			r_reg.reg_off <= 1'b1;
		end
		else
		begin
			r_reg <= r_next;
		end
	end

	// outputs straight from the state register
	assign rdata_out                 = r_reg.rdata;
	assign charge_enable_out         = r_reg.charge_on;
	assign supply_target_level_out   = r_reg.target;
	assign charge_current_level_out  = r_reg.current;
	assign supply_regulation_off_out = r_reg.reg_off;
	assign supply_level_reached_out  = r_reg.reached;

	// checks
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!rst_n_in);

	// helper terms read only by the checks
	logic in_suspend;
	logic in_hold;
	logic below_target;
	assign in_suspend   = (r_reg.state == tsc_pkg::TSC_ST_SUSPEND);
	assign in_hold      = (r_reg.state == tsc_pkg::TSC_ST_HOLD);
	assign below_target = !r_reg.above;

	// multi-step behaviours are built from these sequences
	sequence s_suspend_request;
		in_suspend && req_set_evt && !r_reg.reg_off;
	endsequence

	sequence s_listen_stop;
		suppress_hit && !req_set_evt && !r_reg.reg_off && (r_reg.state != tsc_pkg::TSC_ST_OFF);
	endsequence

	// nothing charges while regulation is off
	chk_off_no_charge: assert property (r_reg.reg_off |=> !charge_enable_out)
		else $error("charger on while regulation off");

	// only a control write can enable regulation
	chk_off_needs_write: assert property (
		$fell(supply_regulation_off_out) |-> $past(wr_ctrl))
		else $error("regulation enabled without a control write");

	// current source drops once the supply is above target
	chk_stop_above: assert property (
		charge_enable_out && r_reg.above |=> !charge_enable_out)
		else $error("charger still on above target");

	// hold re-enables charging as the capacitor sags
	chk_restart_below: assert property (
		in_hold && below_target && !r_reg.reg_off && !suppress_hit |=> charge_enable_out)
		else $error("charger not re-enabled below target");

	// listen-phase stop after a burst that carried no request
	chk_listen_stop: assert property (s_listen_stop |=> in_suspend && !charge_enable_out)
		else $error("charging not stopped after burst");

	// a request write ends a suspension
	chk_request_rearm: assert property (s_suspend_request |=> charge_enable_out)
		else $error("recharge request ignored");

	// a request present at the burst keeps charging going; the monitor must stay
	// low and no control write may land, else hold or off would be legitimate
	chk_request_keeps: assert property (
		burst_end && r_reg.req_at_burst && !r_reg.reg_off && !r_reg.above
		&& !r_reg.above_sync[2] && !wr_ctrl
		&& (r_reg.state == tsc_pkg::TSC_ST_CHARGE) |=> charge_enable_out [*2])
		else $error("charging stopped despite request");

	// level flag tracks the filtered monitor while regulation is on
	chk_reached_flag: assert property (
		supply_level_reached_out == (r_reg.above && !$past(supply_regulation_off_out)))
		else $error("level flag disagrees with monitor");

	// current level lands one edge after its write
	chk_current_write: assert property (
		wr_level |=> charge_current_level_out == $past(wdata_current))
		else $error("current level not stored");

	// filter output moves only to the value both late stages agree on
	chk_target_sync: assert property (
		$changed(r_reg.above) |-> $past(r_reg.above_sync[2]) == r_reg.above)
		else $error("monitor level taken before agreement");

	// a new target lands one edge after its write
	chk_target_write: assert property (
		wr_level |=> supply_target_level_out == $past(wdata_target))
		else $error("target level not stored");

	// target and current only move on a level write
	chk_target_stable: assert property (!wr_level |=> $stable(supply_target_level_out))
		else $error("target level changed without a write");

	chk_current_stable: assert property (!wr_level |=> $stable(charge_current_level_out))
		else $error("current level changed without a write");

	// the off bit follows control writes and nothing else
	chk_off_write: assert property (
		wr_ctrl |=> supply_regulation_off_out == $past(wdata_in[`TSC_CTRL_REG_OFF_BIT]))
		else $error("regulation-off bit not stored");

	chk_off_stable: assert property (!wr_ctrl |=> $stable(supply_regulation_off_out))
		else $error("regulation-off bit changed without a write");

	// the filter holds its output while stages two and three disagree
	chk_above_filter: assert property (
		r_reg.above_sync[1] != r_reg.above_sync[2] |=> $stable(r_reg.above))
		else $error("monitor level moved on a glitch");

	// suspension is only entered through the listen-phase stop
	chk_suspend_entry: assert property (!suppress_hit && !in_suspend |=> !in_suspend)
		else $error("charger suspended outside a burst end");

	// once suspended, only a request or the off bit releases the charger
	chk_suspend_holds: assert property (
		in_suspend && !req_set_evt && !r_reg.reg_off |=> in_suspend)
		else $error("suspension released without a request");

	// regulation off clears any suspension as well
	chk_off_clears: assert property (r_reg.reg_off |=> !in_suspend)
		else $error("suspension kept while regulation off");

	// the request is sampled when the burst begins
	chk_request_sampled: assert property (
		burst_start |=> r_reg.req_at_burst == $past(r_reg.request))
		else $error("request not captured at burst start");

	// status and control reads return the live flags one cycle later
	chk_status_read: assert property (
		rd_status |=> rdata_out[`TSC_STAT_REACHED_BIT] == $past(supply_level_reached_out))
		else $error("status read lost the level flag");

	chk_ctrl_read: assert property (
		rd_in && (addr_in == `TSC_ADDR_CTRL)
		|=> rdata_out[`TSC_CTRL_REG_OFF_BIT] == $past(supply_regulation_off_out))
		else $error("control read lost the off bit");

	// read data stand for one cycle only, zero otherwise
	chk_rdata_idle: assert property (!rd_in |=> rdata_out == 8'h00)
		else $error("read data outside a read cycle");

endmodule

/* File: tsc_supply_model.sv */
// behavioural supply capacitor and level comparator beside the charger
`timescale 1ns/1ns

module tsc_supply_model (
	input  wire logic       clk_sys_in,
	input  wire logic       rst_n_in,
	input  wire logic       charge_en_in,
	input  wire logic       burst_in,
	input  wire logic [3:0] target_in,
	output logic            above_out
);
	logic [7:0] level_reg;
	logic [3:0] leak_reg;

	// a burst empties the cap; slow leak so recharge comes back intermittently
	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			level_reg <= 8'h00;
			leak_reg  <= 4'h0;
		end
		else
		begin
			leak_reg <= leak_reg + 4'h1;
			if (burst_in)
				level_reg <= 8'h00;
			else if (charge_en_in && level_reg != 8'hff)
				level_reg <= level_reg + 8'h01;
			else if (leak_reg == 4'h0 && level_reg != 8'h00)
				level_reg <= level_reg - 8'h01;
		end
	end

	// comparator threshold scales with the target code
	assign above_out = level_reg[7:2] > {2'h0, target_in};
endmodule

/* File: tb.sv */
// self-checking bench for the supply charge control block
`timescale 1ns/1ns
`include "tsc_defines.svh"

module tb;
	logic       clk_sys_in;
	logic       rst_n_in;
	logic [3:0] addr_in;
	logic [7:0] wdata_in;
	logic       wr_in;
	logic       rd_in;
	logic       above;
	logic       burst;
	logic [7:0] rdata;
	logic       ce;
	logic [3:0] tgt;
	logic [3:0] cur;
	logic       off;
	logic       rch;
	int         n_mismatch = 0;
	int         check_count = 0;
	int         cyc = 0;

	tsc_charge_ctrl u_dut (
		.clk_sys_in               (clk_sys_in),
		.rst_n_in                 (rst_n_in),
		.addr_in                  (addr_in),
		.wdata_in                 (wdata_in),
		.wr_in                    (wr_in),
		.rd_in                    (rd_in),
		.supply_above_target_in   (above),
		.burst_active_in          (burst),
		.rdata_out                (rdata),
		.charge_enable_out        (ce),
		.supply_target_level_out  (tgt),
		.charge_current_level_out (cur),
		.supply_regulation_off_out(off),
		.supply_level_reached_out (rch)
	);

	tsc_supply_model u_cap (
		.clk_sys_in  (clk_sys_in),
		.rst_n_in    (rst_n_in),
		.charge_en_in(ce),
		.burst_in    (burst),
		.target_in   (tgt),
		.above_out   (above)
	);

	// free-running clock, 50 ns period
	initial
	begin
		clk_sys_in = 1'b0;
		forever #25 clk_sys_in = ~clk_sys_in;
	end

	task finish_test;
		$display("mismatches %0d checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one-cycle strobes; read data stand only in the following cycle
	task wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk_sys_in);
		wr_in    <= 1'b1;
		addr_in  <= a;
		wdata_in <= v;
		@(posedge clk_sys_in);
		wr_in <= 1'b0;
		#1;
	endtask

	task rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk_sys_in);
		rd_in   <= 1'b1;
		addr_in <= a;
		@(posedge clk_sys_in);
		rd_in <= 1'b0;
		#1;
		check(rdata, exp);
	endtask

	// bounded wait on the charger output, then compare
	task automatic wait_ce(input logic v, input int n);
		int i;
		i = 0;
		while (ce !== v && i < n)
		begin
			@(posedge clk_sys_in);
			#1;
			i++;
		end
		check({7'h0, ce}, {7'h0, v});
	endtask

	task hold0(input int n);
		repeat (n)
		begin
			@(posedge clk_sys_in);
			#1;
			check({7'h0, ce}, 8'h00);
		end
	endtask

	// short burst; settle a few cycles so a suspension can land
	task burst_run;
		@(posedge clk_sys_in);
		burst <= 1'b1;
		repeat (4) @(posedge clk_sys_in);
		burst <= 1'b0;
		repeat (3) @(posedge clk_sys_in);
		#1;
	endtask

	// hang guard well above the expected run length
	always @(posedge clk_sys_in)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			n_mismatch++;
			finish_test;
		end
	end

	initial
	begin
		addr_in  = 4'h0;
		wdata_in = 8'h00;
		wr_in    = 1'b0;
		rd_in    = 1'b0;
		burst    = 1'b0;
		rst_n_in = 1'b0;
		repeat (2) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		@(posedge clk_sys_in);
		#1;
		check({7'h0, off}, 8'h01);
		check({7'h0, ce}, 8'h00);
		check({7'h0, rch}, 8'h00);
		rd(`TSC_ADDR_CTRL, `TSC_CTRL_RESET);
		rd(`TSC_ADDR_STATUS, 8'h08);
		rd(4'hf, 8'h00);
		wr(`TSC_ADDR_LEVEL, 8'h53);
		rd(`TSC_ADDR_LEVEL, 8'h53);
		check({tgt, cur}, 8'h35);
		wr(`TSC_ADDR_CTRL, 8'h00);
		check({7'h0, off}, 8'h00);
		wait_ce(1'b1, 4);
		wait_ce(1'b0, 60);
		check({7'h0, rch}, 8'h01);
		rd(`TSC_ADDR_STATUS, 8'h01);
		wait_ce(1'b1, 200);
		burst_run;
		check({7'h0, ce}, 8'h01);
		wr(`TSC_ADDR_CTRL, 8'h02);
		burst_run;
		hold0(40);
		rd(`TSC_ADDR_STATUS, 8'h04);
		wr(`TSC_ADDR_CTRL, 8'h06);
		wait_ce(1'b1, 4);
		rd(`TSC_ADDR_CTRL, 8'h06);
		burst_run;
		check({7'h0, ce}, 8'h01);
		wr(`TSC_ADDR_CTRL, 8'h03);
		burst_run;
		hold0(20);
		rd(`TSC_ADDR_STATUS, 8'h08);
		wr(`TSC_ADDR_CTRL, 8'h07);
		hold0(10);
		wr(`TSC_ADDR_CTRL, 8'h00);
		check({7'h0, off}, 8'h00);
		wait_ce(1'b1, 4);
		// reset again mid-run: regulation must come back switched off
		rst_n_in <= 1'b0;
		repeat (2) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		@(posedge clk_sys_in);
		#1;
		check({7'h0, off}, 8'h01);
		check({7'h0, ce}, 8'h00);
		check({7'h0, rch}, 8'h00);
		finish_test;
	end
endmodule
